/* hdl/dsp_ctrl.sv */
// dsp_ctrl: deep sleep power controller with wishbone registers.
// assumes the cpu pulses sleep_req on wait-for-interrupt and that the
// debug port levels and wake pins arrive asynchronously.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
module dsp_ctrl
	import dsp_pkg::*;
#(
	parameter int STARTUP_CYC = DSP_STARTUP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// wishbone slave
	input dsp_pkg::dsp_wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// cpu side
	input wire logic sleep_req,
	output logic idle_sleep,
	// wake sources: async pins and timer events
	input wire logic [1:0] pin_wake_async,
	input wire logic timer_wake,
	// debug port requests (async)
	input wire logic debug_powerup_request,
	input wire logic system_powerup_request,
	// power and reset outputs
	output dsp_pkg::dsp_pwr_t pwr,
	// ext_regulator_enable_pin: open drain, only ever pulled low
	output logic ext_regulator_enable_pin_o,
	output logic ext_regulator_enable_pin_oe
);
	import dsp_pkg::*;

	localparam int CW = $clog2(STARTUP_CYC + 1);

	typedef struct packed {
		dsp_state_t state;
		logic [3:0] ctrl;
		logic rc_off_sleep;
		logic [CW-1:0] cnt;
		logic dbg_prev;
		logic sys_prev;
		logic [31:0] dat;
		logic ack;
		logic idle;
		dsp_pwr_t pwr;
	} dsp_st_t;

	dsp_st_t st_ff, nxt_st;
	logic [3:0] sync_q;
	logic dbg_req, sys_req;
	logic [1:0] pin_wake;
	logic timer_ok, wake_ev, wb_hit;

	// async levels through two flops before any logic reads them
	dsp_sync #(.W(4)) u_sync (
		.clk(clk),
		.srst(srst),
		.d({debug_powerup_request, system_powerup_request, pin_wake_async}),
		.q(sync_q)
	);
	assign dbg_req = sync_q[3];
	assign sys_req = sync_q[2];
	assign pin_wake = sync_q[1:0];

	// timers only count when their clock survives the sleep variant
	assign timer_ok = !st_ff.rc_off_sleep || st_ff.ctrl[DSP_CTRL_XTAL_BIT];
	// debug rising edges wake as well, using synchronised levels only
	assign wake_ev = (|pin_wake)
		|| (timer_wake && timer_ok)
		|| (dbg_req && !st_ff.dbg_prev)
		|| (sys_req && !st_ff.sys_prev);
	assign wb_hit = wb_req.cyc && wb_req.stb && !st_ff.ack;

	// next state: bus, power sequencing and outputs
	always_comb begin
		nxt_st = st_ff;
		nxt_st.dbg_prev = dbg_req;
		nxt_st.sys_prev = sys_req;
		nxt_st.ack = wb_hit;
		nxt_st.idle = 1'b0;
		// single cycle ack; unmapped reads give zero, writes dropped
		if (wb_hit) begin
			nxt_st.dat = 32'h0000_0000;
			if (wb_req.adr == DSP_CTRL_OFS) begin
				if (wb_req.we && wb_req.sel[0]) begin
					nxt_st.ctrl = wb_req.dat[3:0];
				end
				nxt_st.dat = {28'h000_0000, st_ff.ctrl};
			end else if (wb_req.adr == DSP_STAT_OFS) begin
				nxt_st.dat = {26'h000_0000, st_ff.rc_off_sleep,
					dbg_req, sys_req, st_ff.state};
			end
		end
		case (st_ff.state)
			DSP_RUN: begin
				if (sleep_req && st_ff.ctrl[DSP_CTRL_SELECT_BIT]) begin
					nxt_st.rc_off_sleep = !st_ff.ctrl[DSP_CTRL_KEEP_BIT];
					nxt_st.state = DSP_PRE;
				end else if (sleep_req) begin
					nxt_st.idle = 1'b1;
				end
			end
			DSP_PRE: begin
				// withhold everything while the debugger reads memory
				if (wake_ev) begin
					nxt_st.state = DSP_RUN;
					nxt_st.rc_off_sleep = 1'b0;
				end else if (dbg_req && !sys_req) begin
					nxt_st.state = DSP_EMUL;
					nxt_st.cnt = CW'(DSP_PERIPH_RST_CYC);
				end else if (!dbg_req && !sys_req) begin
					nxt_st.state = DSP_SLEEP;
				end
				// sys_req set: stay here
			end
			DSP_SLEEP: begin
				if (wake_ev) begin
					nxt_st.state = DSP_WAKE;
					nxt_st.rc_off_sleep = 1'b0;
					nxt_st.cnt = CW'(STARTUP_CYC);
				end
			end
			DSP_WAKE: begin
				if (st_ff.cnt != '0) begin
					nxt_st.cnt = st_ff.cnt - CW'(1);
				end else begin
					nxt_st.state = DSP_RUN;
				end
			end
			DSP_EMUL: begin
				if (st_ff.cnt != '0) begin
					nxt_st.cnt = st_ff.cnt - CW'(1);
				end
				if (!dbg_req || wake_ev) begin
					nxt_st.state = DSP_RUN;
				end
			end
			default: nxt_st.state = DSP_RUN;
		endcase
		// output decode from the next state so outputs are registered
		nxt_st.pwr.rc_osc_en = !(nxt_st.state == DSP_SLEEP
			&& nxt_st.rc_off_sleep);
		nxt_st.pwr.timer_clk_en = nxt_st.pwr.rc_osc_en
			|| nxt_st.ctrl[DSP_CTRL_XTAL_BIT];
		nxt_st.pwr.core_pwr_en = (nxt_st.state != DSP_SLEEP);
		nxt_st.pwr.int_reg_en = (nxt_st.state != DSP_SLEEP)
			&& nxt_st.ctrl[DSP_CTRL_IREG_BIT];
		nxt_st.pwr.cpu_rst = (nxt_st.state == DSP_SLEEP)
			|| (nxt_st.state == DSP_WAKE);
		nxt_st.pwr.periph_rst = (nxt_st.state == DSP_EMUL);
		nxt_st.pwr.ext_reg_oe = (nxt_st.state == DSP_SLEEP);
		// debugger held off until power is back and stable
		nxt_st.pwr.dbg_stall = (nxt_st.state == DSP_SLEEP)
			|| (nxt_st.state == DSP_WAKE);
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.state <= DSP_RUN;
			st_ff.ctrl <= DSP_CTRL_RST;
			st_ff.pwr.rc_osc_en <= 1'b1;
			st_ff.pwr.timer_clk_en <= 1'b1;
			st_ff.pwr.core_pwr_en <= 1'b1;
			st_ff.pwr.int_reg_en <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wb_dat_o = st_ff.dat;
	assign wb_ack_o = st_ff.ack;
	assign idle_sleep = st_ff.idle;
	assign pwr = st_ff.pwr;
	assign ext_regulator_enable_pin_o = 1'b0;
	assign ext_regulator_enable_pin_oe = st_ff.pwr.ext_reg_oe;

	// checks
	property p_emul_only(d, s);
		@(posedge clk) disable iff (srst)
		(st_ff.state == DSP_PRE && d && !s && !wake_ev)
			|=> st_ff.state == DSP_EMUL;
	endproperty
	a_emul_only: assert property (p_emul_only(dbg_req, sys_req))
		else $error("debug request did not lead to emulated sleep");

	property p_emul_power;
		@(posedge clk) disable iff (srst)
		st_ff.state == DSP_EMUL |-> pwr.core_pwr_en && pwr.periph_rst;
	endproperty
	a_emul_power: assert property (p_emul_power)
		else $error("emulated sleep lost core power or peripheral reset");

	property p_sys_hold;
		@(posedge clk) disable iff (srst)
		(st_ff.state == DSP_PRE && sys_req && !wake_ev)
			|=> st_ff.state == DSP_PRE;
	endproperty
	a_sys_hold: assert property (p_sys_hold)
		else $error("sleep entered while system request set");

	property p_true_sleep;
		@(posedge clk) disable iff (srst)
		$rose(st_ff.state == DSP_SLEEP) |-> !$past(dbg_req) && !$past(sys_req);
	endproperty
	a_true_sleep: assert property (p_true_sleep)
		else $error("true sleep entered with a debug request set");

	property p_sleep_pins;
		@(posedge clk) disable iff (srst)
		st_ff.state == DSP_SLEEP |-> ext_regulator_enable_pin_oe
			&& !pwr.int_reg_en && !pwr.core_pwr_en && pwr.dbg_stall;
	endproperty
	a_sleep_pins: assert property (p_sleep_pins)
		else $error("sleep outputs wrong");

	property p_wake_rc;
		@(posedge clk) disable iff (srst)
		(st_ff.state == DSP_SLEEP && wake_ev) |=> pwr.rc_osc_en
			&& pwr.cpu_rst && st_ff.state == DSP_WAKE;
	endproperty
	a_wake_rc: assert property (p_wake_rc)
		else $error("wake did not restart rc oscillator");

	property p_abort;
		@(posedge clk) disable iff (srst)
		(st_ff.state == DSP_PRE && wake_ev) |=> st_ff.state == DSP_RUN
			&& pwr.core_pwr_en;
	endproperty
	a_abort: assert property (p_abort)
		else $error("pending wake did not abandon sleep");

	property p_rc_off;
		@(posedge clk) disable iff (srst)
		(st_ff.state == DSP_SLEEP && st_ff.rc_off_sleep) |-> !pwr.rc_osc_en;
	endproperty
	a_rc_off: assert property (p_rc_off)
		else $error("rc oscillator running in rc-off sleep");

	property p_ack;
		@(posedge clk) disable iff (srst)
		(wb_req.cyc && wb_req.stb && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("wishbone ack not single cycle");

	c_emul: cover property (@(posedge clk) st_ff.state == DSP_EMUL);
	c_sleep: cover property (@(posedge clk) st_ff.state == DSP_SLEEP);
	c_wake: cover property (@(posedge clk)
		st_ff.state == DSP_WAKE ##1 st_ff.state == DSP_RUN);
endmodule // dsp_ctrl

/* hdl/dsp_pkg.sv */
// dsp_pkg: shared constants, register map and types of the deep sleep
// power controller. assumes a 32-bit classic wishbone register bus.
package dsp_pkg;
	// register word offsets (byte addresses)
	localparam logic [7:0] DSP_CTRL_OFS = 8'h00;
	localparam logic [7:0] DSP_STAT_OFS = 8'h04;
	// control register field positions
	localparam int DSP_CTRL_SELECT_BIT = 0; // deep_sleep_select
	localparam int DSP_CTRL_KEEP_BIT = 1; // rc_clock_keep_enable
	localparam int DSP_CTRL_XTAL_BIT = 2; // timers on 32.768 khz crystal
	localparam int DSP_CTRL_IREG_BIT = 3; // internal regulators enable
	// reset values
	localparam logic [3:0] DSP_CTRL_RST = 4'hA; // keep rc on, regs on
	// timing: regulator start-up before core release
	localparam int DSP_CLK_HZ = 25_000_000;
	localparam int DSP_STARTUP_US = 50;
	localparam int DSP_STARTUP_CYC = (DSP_STARTUP_US * (DSP_CLK_HZ / 1_000_000));
	localparam int DSP_PERIPH_RST_CYC = 4;

	// power states, gray coded along run > pre > sleep > wake
	typedef enum logic [2:0] {
		DSP_RUN = 3'b000,
		DSP_PRE = 3'b001,
		DSP_SLEEP = 3'b011,
		DSP_WAKE = 3'b010,
		DSP_EMUL = 3'b110
	} dsp_state_t;

	// wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} dsp_wb_req_t;

	// power outputs toward the analog and reset fabric
	typedef struct packed {
		logic rc_osc_en;
		logic timer_clk_en;
		logic int_reg_en;
		logic core_pwr_en;
		logic cpu_rst;
		logic periph_rst;
		logic ext_reg_oe;
		logic dbg_stall;
	} dsp_pwr_t;
endpackage : dsp_pkg

/* hdl/dsp_sync.sv */
// dsp_sync: two flip-flop synchroniser for a vector of levels.
// assumes inputs may change at any time relative to clk.
module dsp_sync #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dsp_sync_st_t;
	dsp_sync_st_t st_ff, nxt_st;

	// first stage feeds only the second stage
	always_comb begin
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;
endmodule // dsp_sync

/* verification/dsp_dbg_model.sv */
// dsp_dbg_model: debugger on the debug port, request levels only.
// assumes the bench commands connect and access on rising clk edges.
module dsp_dbg_model (
	// clock and commands
	input wire logic clk,
	input wire logic connect,
	input wire logic access,
	// debug port request levels
	output logic debug_powerup_request = 1'b0,
	output logic system_powerup_request = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// held for the whole connection; memory access only while connected
	always @(posedge clk) begin
		debug_powerup_request <= connect;
		system_powerup_request <= connect & access;
	end
endmodule // dsp_dbg_model

/* verification/test_deep_sleep_power_controller.sv */
// test_deep_sleep_power_controller: directed scenarios for dsp_ctrl.
// assumes the debugger model on the debug port, wishbone tasks here.
module test_deep_sleep_power_controller;
	timeunit 1ns;
	timeprecision 1ns;
	import dsp_pkg::*;
	localparam int STARTUP = 8;
	logic clk = 1'b0;
	logic srst = 1'b1;
	dsp_wb_req_t wb_req = '0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic wb_ack_o, idle_sleep, idle_seen, dbg_req, sys_req, ext_o, ext_oe;
	logic sleep_req = 1'b0;
	logic timer_wake = 1'b0;
	logic connect = 1'b0;
	logic access = 1'b0;
	logic [1:0] pin_wake_async = 2'b00;
	dsp_pwr_t pwr;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	// short start-up count keeps each wake to a few cycles
	dsp_ctrl #(.STARTUP_CYC(STARTUP)) DUT (.clk(clk), .srst(srst),
		.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sleep_req(sleep_req), .idle_sleep(idle_sleep),
		.pin_wake_async(pin_wake_async), .timer_wake(timer_wake),
		.debug_powerup_request(dbg_req), .system_powerup_request(sys_req),
		.pwr(pwr), .ext_regulator_enable_pin_o(ext_o),
		.ext_regulator_enable_pin_oe(ext_oe));
	dsp_dbg_model dbg (.clk(clk), .connect(connect), .access(access),
		.debug_powerup_request(dbg_req), .system_powerup_request(sys_req));
	always #20 clk = ~clk;
	// hang guard: whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one classic cycle, held until ack is sampled high
	// no wait limit here: only the hang guard may end a missing ack
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_req <= '0;
		@(posedge clk);
	endtask
	task automatic state_is(input logic [5:0] exp);
		wb(1'b0, DSP_STAT_OFS, 32'h0);
		chk("status", {26'h0, exp}, {26'h0, rd[5:0]});
	endtask
	// one-cycle wait-for-interrupt pulse, idle flag seen next cycle
	task automatic sleep_pulse();
		@(posedge clk);
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		@(posedge clk);
		idle_seen = idle_sleep;
		repeat (4) @(posedge clk);
	endtask
	// wake: processor reset and stalled debugger, then power back on
	task automatic wake_seq(input logic [5:0] exp_stat);
		int n;
		n = 0;
		while (pwr.cpu_rst !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk("cpu_rst", 1, pwr.cpu_rst);
		chk("dbg_stall", 1, pwr.dbg_stall);
		repeat (STARTUP + 4) @(posedge clk);
		chk("int_reg_en", 1, pwr.int_reg_en);
		chk("ext_oe", 0, ext_oe);
		// status keeps the debug level bits of a connected debugger
		state_is(exp_stat);
		chk("cpu_rst", 0, pwr.cpu_rst);
		chk("dbg_stall", 0, pwr.dbg_stall);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		wb(1'b0, DSP_CTRL_OFS, 32'h0);
		chk("ctrl", 32'h0000_000A, rd);
		wb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 0, rd);
		sleep_pulse();
		chk("idle", 1, idle_seen);
		// oscillator kept, timer wake allowed
		wb(1'b1, DSP_CTRL_OFS, 32'h0000_000B);
		sleep_pulse();
		chk("idle", 0, idle_seen);
		state_is(6'h03);
		chk("rc_osc_en", 1, pwr.rc_osc_en);
		chk("int_reg_en", 0, pwr.int_reg_en);
		chk("ext_oe", 1, ext_oe);
		chk("ext_o", 0, ext_o);
		timer_wake <= 1'b1;
		@(posedge clk);
		timer_wake <= 1'b0;
		wake_seq(6'h00);
		// oscillator off: timer ignored, pin wakes and restarts it
		wb(1'b1, DSP_CTRL_OFS, 32'h0000_0009);
		sleep_pulse();
		state_is(6'h23);
		chk("rc_osc_en", 0, pwr.rc_osc_en);
		chk("timer_clk_en", 0, pwr.timer_clk_en);
		timer_wake <= 1'b1;
		repeat (3) @(posedge clk);
		timer_wake <= 1'b0;
		state_is(6'h23);
		pin_wake_async <= 2'b10;
		wake_seq(6'h00);
		chk("rc_osc_en", 1, pwr.rc_osc_en);
		pin_wake_async <= 2'b00;
		// wake pending at the request abandons the power-down
		wb(1'b1, DSP_CTRL_OFS, 32'h0000_000B);
		pin_wake_async <= 2'b01;
		repeat (4) @(posedge clk);
		sleep_pulse();
		state_is(6'h00);
		pin_wake_async <= 2'b00;
		// debugger connected: emulated sleep only
		connect <= 1'b1;
		repeat (4) @(posedge clk);
		sleep_pulse();
		state_is(6'h16);
		chk("core_pwr_en", 1, pwr.core_pwr_en);
		chk("periph_rst", 1, pwr.periph_rst);
		chk("cpu_rst", 0, pwr.cpu_rst);
		connect <= 1'b0;
		repeat (6) @(posedge clk);
		state_is(6'h00);
		// memory access withholds entry; reconnect wakes
		connect <= 1'b1;
		access <= 1'b1;
		repeat (4) @(posedge clk);
		sleep_pulse();
		state_is(6'h19);
		connect <= 1'b0;
		access <= 1'b0;
		repeat (6) @(posedge clk);
		state_is(6'h03);
		connect <= 1'b1;
		wake_seq(6'h10);
		connect <= 1'b0;
		// external supply: software turns the internal regulators off
		wb(1'b1, DSP_CTRL_OFS, 32'h0000_0002);
		chk("int_reg_en", 0, pwr.int_reg_en);
		complete_run();
	end
endmodule // test_deep_sleep_power_controller
